// *** verilog/uart_consts.svh ***
// Offsets, field positions, reset values and timing counts of the serial unit
//
// Notes on behaviour
// [R1] Frame: start bit, data LSB first, optional parity, then one or two stop bits.
// [R2] Receiver checks overrun, parity, framing, break; flags stored with each character.
// [R3] Baud divisor is 22 bits: 16 integer bits plus 6 fraction bits.
// [R4] Reference tick runs at 16x baud; 16 ticks per bit, rx sampling shares it.
// [R5] Software rounds the fraction field as integer(fraction * 64 + 0.5).
// [R6] Divisors and line control load together, only on a line-control write.
// [R7] Both FIFOs hold 16 characters; rx entries add four status bits.
// [R8] Enabled unit transmits from its FIFO until the FIFO runs empty.
// [R9] Busy rises with a non-empty tx FIFO, falls after the last stop bit.
// [R10] Falling edge starts rx counter; start kept only if low on the eighth tick.
// [R11] Data bits sampled every sixteenth tick, then parity checked when enabled.
// [R12] Low stop sample is a framing error; character stored with its error bits.
// [R13] Data reads give 8 data plus 4 error bits; writes push 8 bits.
// [R14] After reset FIFOs are one entry deep; the FIFO-enable bit gives full depth.
// [R15] Flag register shows tx/rx empty and full; status register shows overrun.
// [R16] Tx and rx trigger levels selectable 1/8..7/8, both half after reset.
// [R17] Seven interrupt sources are ORed onto one request line.
// [R18] Mask bit 1 passes a source; raw status always readable, masked shows pending.
// [R19] Writing 1 to an interrupt-clear bit clears raw and masked status.
// [R20] Rx flag sets at the trigger level, clears below it or on its clear bit.
// [R21] Tx flag sets at the trigger level, clears above it or on its clear bit.
// [R22] Loopback routes the serial output back into the receiver.
// [R23] Transmit and receive enables select each direction, both set after reset.
// [R24] Software disables before reprogramming; a character in flight is finished.
// [R25] Receive timeout fires when rx data waits for several idle character times.
`ifndef UART_CONSTS_SVH
`define UART_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_DATA 12'h000
`define OFS_RX_STATUS 12'h004
`define OFS_FLAG 12'h018
`define OFS_INT_DIV 12'h024
`define OFS_FRAC_DIV 12'h028
`define OFS_LINE_CTRL 12'h02C
`define OFS_CONTROL 12'h030
`define OFS_LEVEL_SEL 12'h034
`define OFS_INT_MASK 12'h038
`define OFS_RAW_INT 12'h03C
`define OFS_MASKED_INT 12'h040
`define OFS_INT_CLEAR 12'h044

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LC_BREAK 0
`define LC_PAR_EN 1
`define LC_EVEN 2
`define LC_TWO_STOP 3
`define LC_FIFO_EN 4
`define LC_LEN_LO 5
`define LC_STICK 7
`define CT_UNIT_EN 0
`define CT_LOOPBACK 7
`define CT_TX_EN 8
`define CT_RX_EN 9
`define FL_BUSY 3
`define FL_RX_EMPTY 4
`define FL_TX_FULL 5
`define FL_RX_FULL 6
`define FL_TX_EMPTY 7
`define IR_RX 4
`define IR_TX 5
`define IR_TIMEOUT 6
`define IR_FRAME 7
`define IR_PARITY 8
`define IR_BREAK 9
`define IR_OVERRUN 10

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RST_CONTROL 10'h300
`define RST_LEVEL_SEL 6'h12
`define TICKS_PER_BIT 16
`define TIMEOUT_BITS 32
`define TIMEOUT_TICKS (`TIMEOUT_BITS * `TICKS_PER_BIT)

`endif

// *** verilog/uart_pkg.sv ***
// Types shared by the serial unit
`default_nettype none
package uart_pkg;
	typedef enum logic [2:0] {
		FS_IDLE = 3'h0,
		FS_START = 3'h1,
		FS_DATA = 3'h3,
		FS_PARITY = 3'h2,
		FS_STOP = 3'h6
	} frame_state_t;

	typedef struct packed {
		logic overrun;
		logic brk;
		logic parity;
		logic frame;
		logic [7:0] data;
	} rx_entry_t;

	typedef struct packed {
		logic [15:0] divisor_integer_part;
		logic [5:0] divisor_fraction_part;
		logic [7:0] line;
	} line_cfg_t;
endpackage
`default_nettype wire

// *** verilog/async_serial_transceiver.sv ***
// Serial transceiver with fractional baud generator, FIFOs and APB registers
`default_nettype none
`include "uart_consts.svh"

module async_serial_transceiver #(
	parameter int DEPTH = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_rx_line,
	output logic serial_tx_line,
	output logic irq
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 8 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
		$error("DEPTH must be a power of two of at least 8");
	end

	typedef struct packed {
		uart_pkg::line_cfg_t cfg;
		logic [15:0] integer_divisor_reg;
		logic [5:0] fraction_divisor_reg;
		logic [9:0] control_reg;
		logic [5:0] fifo_level_select_reg;
		logic [10:0] interrupt_mask_reg;
		logic [10:0] raw_interrupt_reg;
		logic [3:0] receive_status_reg;
		logic [15:0] baud_cnt;
		logic [5:0] baud_acc;
		logic [DEPTH-1:0][7:0] tx_mem;
		logic [AW-1:0] tx_wp;
		logic [AW-1:0] tx_rp;
		logic [AW:0] tx_cnt;
		logic [DEPTH-1:0][11:0] rx_mem;
		logic [AW-1:0] rx_wp;
		logic [AW-1:0] rx_rp;
		logic [AW:0] rx_cnt;
		uart_pkg::frame_state_t tx_state;
		logic [3:0] tx_tick;
		logic [2:0] tx_bit;
		logic [7:0] tx_sh;
		logic tx_par;
		logic tx_line;
		uart_pkg::frame_state_t rx_state;
		logic [3:0] rx_tick;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_pbit;
		logic rx_zero;
		logic rx_prev;
		logic pend_oe;
		logic [9:0] to_cnt;
		logic tx_cond_q;
		logic rx_cond_q;
		logic [31:0] prdata;
	} state_t;

	state_t s;
	state_t next_s;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [AW:0] level_of(input logic [2:0] code);
		logic [AW:0] eighth;
		eighth = (AW + 1)'(DEPTH / 8);
		case (code)
			3'h0: level_of = eighth;
			3'h1: level_of = (AW + 1)'(2 * (DEPTH / 8));
			3'h3: level_of = (AW + 1)'(6 * (DEPTH / 8));
			3'h4: level_of = (AW + 1)'(7 * (DEPTH / 8));
			default: level_of = (AW + 1)'(4 * (DEPTH / 8));
		endcase
	endfunction

	// Parity bit for the first len data bits under the latched line setting
	function automatic logic parity_of(input logic [7:0] d, input logic [7:0] lc);
		logic odd;
		odd = ^(d & (8'hFF >> (2'h3 - lc[`LC_LEN_LO+:2])));
		if (lc[`LC_STICK]) begin
			parity_of = ~lc[`LC_EVEN];
		end else begin
			parity_of = lc[`LC_EVEN] ? odd : ~odd;
		end
	endfunction

	logic fifo_enable;
	logic [AW:0] cap;
	logic [2:0] last_bit;
	logic tick;
	logic rx_in;
	logic acc;
	logic wr;
	logic rd;
	logic [11:0] addr;
	logic unit_on;
	logic tx_push;
	logic tx_pop;
	logic rx_push;
	logic rx_pop;
	logic tx_cond;
	logic rx_cond;
	logic [31:0] rdata;
	logic mapped;
	logic busy;
	logic [6:0] carry_sum;
	uart_pkg::rx_entry_t rx_word;

	assign fifo_enable = s.cfg.line[`LC_FIFO_EN];
	assign cap = fifo_enable ? (AW + 1)'(DEPTH) : (AW + 1)'(1); // [R7] [R14]
	assign last_bit = {1'b1, s.cfg.line[`LC_LEN_LO+:2]};
	assign rx_in = s.control_reg[`CT_LOOPBACK] ? s.tx_line : serial_rx_line; // [R22]
	assign unit_on = s.control_reg[`CT_UNIT_EN];
	assign busy = (s.tx_cnt != '0) || (s.tx_state != uart_pkg::FS_IDLE); // [R9]
	assign addr = {paddr[11:2], 2'b00};
	assign acc = psel && penable && ce;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign pready = ce;
	assign pslverr = acc && !mapped;
	assign prdata = s.prdata;
	assign serial_tx_line = s.tx_line;
	assign irq = |(s.raw_interrupt_reg & s.interrupt_mask_reg); // [R17] [R18]
	assign tick = ce && (s.cfg.divisor_integer_part != 16'h0000) && (s.baud_cnt == 16'h0000);
	assign carry_sum = {1'b0, s.baud_acc} + {1'b0, s.cfg.divisor_fraction_part};
	assign tx_cond = fifo_enable ? (s.tx_cnt <= level_of(s.fifo_level_select_reg[2:0]))
		: (s.tx_cnt == '0); // [R21]
	assign rx_cond = fifo_enable ? (s.rx_cnt >= level_of(s.fifo_level_select_reg[5:3]))
		: (s.rx_cnt != '0); // [R20]

	// ----------------------------------------
	// Register read mux
	// ----------------------------------------
	always_comb begin
		rdata = 32'h0000_0000;
		mapped = 1'b1;
		if (addr == `OFS_DATA) begin
			rdata = {20'h00000, s.rx_mem[s.rx_rp]}; // [R13]
		end else if (addr == `OFS_RX_STATUS) begin
			rdata = {28'h0000000, s.receive_status_reg}; // [R15]
		end else if (addr == `OFS_FLAG) begin
			rdata[`FL_BUSY] = busy;
			rdata[`FL_RX_EMPTY] = (s.rx_cnt == '0); // [R15]
			rdata[`FL_TX_FULL] = (s.tx_cnt == cap);
			rdata[`FL_RX_FULL] = (s.rx_cnt == cap);
			rdata[`FL_TX_EMPTY] = (s.tx_cnt == '0);
		end else if (addr == `OFS_INT_DIV) begin
			rdata = {16'h0000, s.integer_divisor_reg};
		end else if (addr == `OFS_FRAC_DIV) begin
			rdata = {26'h0000000, s.fraction_divisor_reg};
		end else if (addr == `OFS_LINE_CTRL) begin
			rdata = {24'h000000, s.cfg.line};
		end else if (addr == `OFS_CONTROL) begin
			rdata = {22'h000000, s.control_reg};
		end else if (addr == `OFS_LEVEL_SEL) begin
			rdata = {26'h0000000, s.fifo_level_select_reg};
		end else if (addr == `OFS_INT_MASK) begin
			rdata = {21'h000000, s.interrupt_mask_reg};
		end else if (addr == `OFS_RAW_INT) begin
			rdata = {21'h000000, s.raw_interrupt_reg}; // [R18]
		end else if (addr == `OFS_MASKED_INT) begin
			rdata = {21'h000000, s.raw_interrupt_reg & s.interrupt_mask_reg};
		end else if (addr == `OFS_INT_CLEAR) begin
			rdata = 32'h0000_0000;
		end else begin
			mapped = 1'b0;
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		tx_push = 1'b0;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		rx_pop = 1'b0;
		rx_word = '0;
		if (psel && !penable) begin
			next_s.prdata = rdata;
		end

		// Baud reference with fractional carry
		if (tick) begin
			next_s.baud_acc = carry_sum[5:0];
			next_s.baud_cnt = s.cfg.divisor_integer_part - 16'h0001 + {15'h0000, carry_sum[6]}; // [R3] [R4]
		end else if (ce && s.baud_cnt != 16'h0000) begin
			next_s.baud_cnt = s.baud_cnt - 16'h0001;
		end

		// Register writes
		if (wr) begin
			if (addr == `OFS_DATA && s.tx_cnt != cap) begin
				tx_push = 1'b1; // [R13]
				next_s.tx_mem[s.tx_wp] = pwdata[7:0];
			end else if (addr == `OFS_RX_STATUS) begin
				next_s.receive_status_reg = 4'h0;
			end else if (addr == `OFS_INT_DIV) begin
				next_s.integer_divisor_reg = pwdata[15:0];
			end else if (addr == `OFS_FRAC_DIV) begin
				next_s.fraction_divisor_reg = pwdata[5:0];
			end else if (addr == `OFS_LINE_CTRL) begin
				next_s.cfg = {s.integer_divisor_reg, s.fraction_divisor_reg, pwdata[7:0]}; // [R6]
			end else if (addr == `OFS_CONTROL) begin
				next_s.control_reg = pwdata[9:0];
			end else if (addr == `OFS_LEVEL_SEL) begin
				next_s.fifo_level_select_reg = pwdata[5:0]; // [R16]
			end else if (addr == `OFS_INT_MASK) begin
				next_s.interrupt_mask_reg = {pwdata[10:4], 4'h0};
			end else if (addr == `OFS_INT_CLEAR) begin
				next_s.raw_interrupt_reg = s.raw_interrupt_reg & ~{pwdata[10:4], 4'h0}; // [R19]
			end
		end
		if (rd && addr == `OFS_DATA && s.rx_cnt != '0) begin
			rx_pop = 1'b1; // [R13]
		end

		// Transmitter: a started character always runs to its stop bits
		if (s.tx_state == uart_pkg::FS_IDLE) begin
			if (tick && s.tx_cnt != '0 && unit_on && s.control_reg[`CT_TX_EN]) begin // [R8] [R23]
				tx_pop = 1'b1;
				next_s.tx_sh = s.tx_mem[s.tx_rp];
				next_s.tx_par = parity_of(s.tx_mem[s.tx_rp], s.cfg.line);
				next_s.tx_state = uart_pkg::FS_START;
				next_s.tx_tick = 4'h0;
				next_s.tx_line = 1'b0; // [R1]
			end else begin
				next_s.tx_line = 1'b1;
			end
		end else if (tick) begin // [R24]
			next_s.tx_tick = s.tx_tick + 4'h1;
			if (s.tx_tick == 4'hF) begin
				next_s.tx_bit = 3'h0;
				case (s.tx_state)
					uart_pkg::FS_START: begin
						next_s.tx_state = uart_pkg::FS_DATA;
						next_s.tx_line = s.tx_sh[0]; // [R1]
					end
					uart_pkg::FS_DATA: begin
						next_s.tx_sh = {1'b0, s.tx_sh[7:1]};
						next_s.tx_bit = s.tx_bit + 3'h1;
						next_s.tx_line = s.tx_sh[1];
						if (s.tx_bit == last_bit) begin
							next_s.tx_bit = 3'h0;
							next_s.tx_state = s.cfg.line[`LC_PAR_EN] ? uart_pkg::FS_PARITY
								: uart_pkg::FS_STOP;
							next_s.tx_line = s.cfg.line[`LC_PAR_EN] ? s.tx_par : 1'b1;
						end
					end
					uart_pkg::FS_PARITY: begin
						next_s.tx_state = uart_pkg::FS_STOP;
						next_s.tx_line = 1'b1;
					end
					uart_pkg::FS_STOP: begin
						next_s.tx_bit = 3'h1;
						if (s.tx_bit == {2'b00, s.cfg.line[`LC_TWO_STOP]}) begin
							next_s.tx_state = uart_pkg::FS_IDLE;
						end
					end
					default: next_s.tx_state = uart_pkg::FS_IDLE;
				endcase
			end
		end
		if (s.cfg.line[`LC_BREAK]) begin
			next_s.tx_line = 1'b0;
		end

		// Receiver
		next_s.rx_prev = rx_in;
		if (s.rx_state == uart_pkg::FS_IDLE) begin
			if (ce && s.rx_prev && !rx_in && unit_on && s.control_reg[`CT_RX_EN]) begin
				next_s.rx_state = uart_pkg::FS_START; // [R10]
				next_s.rx_tick = 4'h0;
				next_s.rx_sh = 8'h00;
				next_s.rx_zero = 1'b1;
			end
		end else if (tick) begin
			next_s.rx_tick = s.rx_tick + 4'h1;
			case (s.rx_state)
				uart_pkg::FS_START: begin
					if (s.rx_tick == 4'h7) begin
						next_s.rx_tick = 4'h0;
						next_s.rx_bit = 3'h0;
						next_s.rx_state = rx_in ? uart_pkg::FS_IDLE : uart_pkg::FS_DATA; // [R10]
					end
				end
				uart_pkg::FS_DATA: begin
					if (s.rx_tick == 4'hF) begin
						next_s.rx_sh[s.rx_bit] = rx_in; // [R11]
						next_s.rx_zero = s.rx_zero && !rx_in;
						next_s.rx_bit = s.rx_bit + 3'h1;
						if (s.rx_bit == last_bit) begin
							next_s.rx_state = s.cfg.line[`LC_PAR_EN] ? uart_pkg::FS_PARITY
								: uart_pkg::FS_STOP;
						end
					end
				end
				uart_pkg::FS_PARITY: begin
					if (s.rx_tick == 4'hF) begin
						next_s.rx_pbit = rx_in; // [R11]
						next_s.rx_zero = s.rx_zero && !rx_in;
						next_s.rx_state = uart_pkg::FS_STOP;
					end
				end
				uart_pkg::FS_STOP: begin
					if (s.rx_tick == 4'hF) begin
						next_s.rx_state = uart_pkg::FS_IDLE;
						rx_word.data = s.rx_sh;
						rx_word.frame = !rx_in; // [R12]
						rx_word.parity = s.cfg.line[`LC_PAR_EN]
							&& (s.rx_pbit != parity_of(s.rx_sh, s.cfg.line));
						rx_word.brk = s.rx_zero && !rx_in; // [R2]
						rx_word.overrun = s.pend_oe;
						if (s.rx_cnt == cap) begin
							next_s.pend_oe = 1'b1; // [R2]
							next_s.receive_status_reg[3] = 1'b1; // [R15]
							next_s.raw_interrupt_reg[`IR_OVERRUN] = 1'b1;
						end else begin
							rx_push = 1'b1; // [R12]
							next_s.pend_oe = 1'b0;
							next_s.rx_mem[s.rx_wp] = rx_word;
							// Built on next_s so a clear in this cycle is kept, a new error still wins
							next_s.receive_status_reg = next_s.receive_status_reg
								| {rx_word.overrun, rx_word.brk, rx_word.parity, rx_word.frame};
							next_s.raw_interrupt_reg[`IR_FRAME] =
								next_s.raw_interrupt_reg[`IR_FRAME] | rx_word.frame; // [R17]
							next_s.raw_interrupt_reg[`IR_PARITY] =
								next_s.raw_interrupt_reg[`IR_PARITY] | rx_word.parity;
							next_s.raw_interrupt_reg[`IR_BREAK] =
								next_s.raw_interrupt_reg[`IR_BREAK] | rx_word.brk;
						end
					end
				end
				default: next_s.rx_state = uart_pkg::FS_IDLE;
			endcase
		end

		// FIFO pointers
		if (tx_push) begin
			next_s.tx_wp = fifo_enable ? s.tx_wp + 1'b1 : s.tx_rp;
		end
		if (tx_push && !fifo_enable) begin
			next_s.tx_mem[s.tx_rp] = pwdata[7:0]; // [R14]
		end
		if (tx_pop) begin
			next_s.tx_rp = fifo_enable ? s.tx_rp + 1'b1 : s.tx_rp;
		end
		next_s.tx_cnt = s.tx_cnt + (AW + 1)'(tx_push) - (AW + 1)'(tx_pop);
		if (rx_push && !fifo_enable) begin
			next_s.rx_mem[s.rx_rp] = rx_word;
		end
		if (rx_push) begin
			next_s.rx_wp = fifo_enable ? s.rx_wp + 1'b1 : s.rx_rp;
		end
		if (rx_pop) begin
			next_s.rx_rp = fifo_enable ? s.rx_rp + 1'b1 : s.rx_rp;
		end
		next_s.rx_cnt = s.rx_cnt + (AW + 1)'(rx_push) - (AW + 1)'(rx_pop);

		// Level flags: clear when condition goes away, set on reaching it
		next_s.tx_cond_q = tx_cond;
		next_s.rx_cond_q = rx_cond;
		if (ce && !tx_cond) begin
			next_s.raw_interrupt_reg[`IR_TX] = 1'b0; // [R21]
		end
		if (ce && !rx_cond) begin
			next_s.raw_interrupt_reg[`IR_RX] = 1'b0; // [R20]
		end
		if (ce && tx_cond && !s.tx_cond_q) begin
			next_s.raw_interrupt_reg[`IR_TX] = 1'b1; // [R21]
		end
		if (ce && rx_cond && !s.rx_cond_q) begin
			next_s.raw_interrupt_reg[`IR_RX] = 1'b1; // [R20]
		end

		// Receive timeout; an incoming character or an empty rx FIFO restarts the idle count
		if (rx_push || s.rx_cnt == '0 || s.rx_state != uart_pkg::FS_IDLE) begin
			next_s.to_cnt = 10'h000;
		end else if (tick && s.to_cnt != 10'(`TIMEOUT_TICKS - 1)) begin
			next_s.to_cnt = s.to_cnt + 10'h001;
			if (s.to_cnt == 10'(`TIMEOUT_TICKS - 2)) begin
				next_s.raw_interrupt_reg[`IR_TIMEOUT] = 1'b1; // [R25]
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.control_reg <= `RST_CONTROL; // [R23]
			s.fifo_level_select_reg <= `RST_LEVEL_SEL; // [R16]
			s.tx_line <= 1'b1;
			s.rx_prev <= 1'b1;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	start_bit_low_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
		s.tx_state == uart_pkg::FS_START |-> !serial_tx_line)
		else $error("start bit not low");
	stop_bit_high_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
		s.tx_state == uart_pkg::FS_STOP && !s.cfg.line[`LC_BREAK] |-> serial_tx_line)
		else $error("stop bit not high");
	busy_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
		wr && addr == `OFS_DATA && s.tx_cnt != cap |=> busy[*2])
		else $error("busy missing after tx write");
	single_entry_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
		!fifo_enable |-> s.tx_cnt <= 1 && s.rx_cnt <= 1)
		else $error("fifo deeper than one while disabled");
	divisor_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
		wr && addr == `OFS_INT_DIV |=> $stable(s.cfg))
		else $error("divisor took effect without line write");
	start_reject_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
		tick && s.rx_state == uart_pkg::FS_START && s.rx_tick == 4'h7 && rx_in
		|=> s.rx_state == uart_pkg::FS_IDLE)
		else $error("false start bit kept");
	rx_pop_a: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
		rx_pop && !rx_push |=> s.rx_cnt == $past(s.rx_cnt) - 1)
		else $error("data read did not pop");
	clear_tx_a: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
		wr && addr == `OFS_INT_CLEAR && pwdata[`IR_TX] && s.tx_cond_q
		&& (s.raw_interrupt_reg & s.interrupt_mask_reg & ~{pwdata[10:4], 4'h0}) == 11'h000
		&& s.rx_state == uart_pkg::FS_IDLE && s.to_cnt == 10'h000
		|=> !s.raw_interrupt_reg[`IR_TX] && !irq)
		else $error("tx flag survived clear");
	mask_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
		s.interrupt_mask_reg == 11'h000 |-> !irq)
		else $error("masked source raised irq");
	frame_err_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		rx_push && !rx_in |=> s.receive_status_reg[0])
		else $error("framing error not flagged");

	tx_done_c: cover property (@(posedge pclk) disable iff (!presetn)
		s.tx_state == uart_pkg::FS_STOP ##1 s.tx_state == uart_pkg::FS_IDLE);
	rx_store_c: cover property (@(posedge pclk) disable iff (!presetn) rx_push);
	overrun_c: cover property (@(posedge pclk) disable iff (!presetn)
		s.raw_interrupt_reg[`IR_OVERRUN]);
	irq_c: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule // async_serial_transceiver
`default_nettype wire

// *** tb/serial_peer.sv ***
// Remote serial device model: sends frames and decodes frames, 8 data bits
`default_nettype none
module serial_peer #(
	parameter int BIT = 40
) (
	input wire logic clk,
	input wire logic tx_in,
	output logic rx_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got;
	int got_cnt = 0;
	initial rx_out = 1'b1;
	// Start low, LSB first, stop level chosen by caller
	task automatic send(input logic [7:0] d, input logic stp);
		logic [9:0] f;
		f = {stp, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_out <= f[i];
			repeat (BIT) @(posedge clk);
		end
		rx_out <= 1'b1;
	endtask
	// Low pulse well short of the mid-start check
	task automatic glitch(input int n);
		rx_out <= 1'b0;
		repeat (n) @(posedge clk);
		rx_out <= 1'b1;
	endtask
	// Sample at bit centres
	always begin
		@(negedge tx_in);
		repeat (BIT / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk);
			got[i] = tx_in;
		end
		repeat (BIT) @(posedge clk);
		got_cnt++;
	end
endmodule // serial_peer
`default_nettype wire

// *** tb/async_serial_transceiver_tb.sv ***
// Self-checking bench for the serial transceiver
`default_nettype none
`include "uart_consts.svh"
module async_serial_transceiver_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Tick of 2.5 clocks: 16 x 2.5 = 40 clocks per bit
	localparam int FRAC = 32;
	localparam int BIT = 40;
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] e;
		logic err;
	} row_t;
	logic pclk, presetn, ce, psel, penable, pwrite, pslverr, pready, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic rx_line, tx_line, rerr;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	row_t rows [6] = '{
		'{`OFS_CONTROL, 32'h0000_0300, 1'b0},
		'{`OFS_LEVEL_SEL, 32'h0000_0012, 1'b0},
		'{`OFS_FLAG, 32'h0000_0090, 1'b0},
		'{`OFS_RAW_INT, 32'h0000_0020, 1'b0},
		'{`OFS_MASKED_INT, 32'h0000_0000, 1'b0},
		'{12'h800, 32'h0000_0000, 1'b1}};

	async_serial_transceiver u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .serial_rx_line(rx_line),
		.serial_tx_line(tx_line), .irq(irq));
	serial_peer #(.BIT(BIT)) u_peer (.clk(pclk), .tx_in(tx_line), .rx_out(rx_line));

	always #5 pclk = ~pclk;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %0t: got %h want %h", $time, s, e);
		end
	endtask
	// Extra edge at the end keeps psel from being driven twice per step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	task automatic stop_test;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			error_cnt++;
			stop_test();
		end
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i]) begin
			apb(1'b0, rows[i].a, 32'h0);
			chk(rdat, rows[i].e);
			chk({31'h0, rerr}, {31'h0, rows[i].err});
		end
		// One held byte while disabled: busy and full at depth one
		apb(1'b1, `OFS_DATA, 32'h0000_00A5);
		rd_chk(`OFS_FLAG, 32'h0000_0038);
		rd_chk(`OFS_RAW_INT, 32'h0000_0000);
		apb(1'b1, `OFS_INT_DIV, 32'h0000_0002);
		apb(1'b1, `OFS_FRAC_DIV, FRAC);
		apb(1'b1, `OFS_LINE_CTRL, 32'h0000_0060);
		apb(1'b1, `OFS_CONTROL, 32'h0000_0301);
		while (u_peer.got_cnt < 1) @(posedge pclk);
		chk({24'h0, u_peer.got}, 32'h0000_00A5);
		repeat (2 * BIT) @(posedge pclk);
		rd_chk(`OFS_FLAG, 32'h0000_0090);
		u_peer.send(8'h3C, 1'b1);
		repeat (BIT) @(posedge pclk);
		rd_chk(`OFS_DATA, 32'h0000_003C);
		// Low stop sample: frame flag stored with the byte
		u_peer.send(8'hC3, 1'b0);
		repeat (BIT) @(posedge pclk);
		rd_chk(`OFS_DATA, 32'h0000_01C3);
		rd_chk(`OFS_RAW_INT, 32'h0000_00A0);
		apb(1'b1, `OFS_INT_MASK, 32'h0000_0080);
		chk({31'h0, irq}, 32'h1);
		rd_chk(`OFS_MASKED_INT, 32'h0000_0080);
		apb(1'b1, `OFS_INT_CLEAR, 32'h0000_00A0);
		rd_chk(`OFS_RAW_INT, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0);
		u_peer.glitch(10);
		repeat (20 * BIT) @(posedge pclk);
		rd_chk(`OFS_FLAG, 32'h0000_0090);
		// Disable before reprogramming, then loop three bytes back
		apb(1'b1, `OFS_CONTROL, 32'h0000_0300);
		apb(1'b1, `OFS_LINE_CTRL, 32'h0000_0070);
		apb(1'b1, `OFS_CONTROL, 32'h0000_0381);
		for (int i = 1; i <= 3; i++)
			apb(1'b1, `OFS_DATA, 32'(i * 17));
		repeat (36 * BIT) @(posedge pclk);
		for (int i = 1; i <= 3; i++)
			rd_chk(`OFS_DATA, 32'(i * 17));
		// Seven bits, even parity, two stops, one-deep: second byte overruns
		apb(1'b1, `OFS_CONTROL, 32'h0000_0300);
		apb(1'b1, `OFS_RX_STATUS, 32'h0000_0000);
		apb(1'b1, `OFS_LINE_CTRL, 32'h0000_004E);
		apb(1'b1, `OFS_CONTROL, 32'h0000_0381);
		apb(1'b1, `OFS_DATA, 32'h0000_00D5);
		repeat (BIT) @(posedge pclk);
		apb(1'b1, `OFS_DATA, 32'h0000_002A);
		// Long idle with a byte waiting also raises the timeout
		repeat (60 * BIT) @(posedge pclk);
		rd_chk(`OFS_RX_STATUS, 32'h0000_0008);
		rd_chk(`OFS_RAW_INT, 32'h0000_0470);
		rd_chk(`OFS_DATA, 32'h0000_0055);
		// Reset in mid-run restores the reset values
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_chk(`OFS_CONTROL, 32'h0000_0300);
		rd_chk(`OFS_LINE_CTRL, 32'h0000_0000);
		rd_chk(`OFS_RAW_INT, 32'h0000_0020);
		stop_test();
	end
endmodule // async_serial_transceiver_tb
`default_nettype wire
